// ===== dcap2_pkg.sv
// Package holding the layout, offsets and defaults of the device capabilities two register.
// Assumes a 32-bit classic Wishbone slave with a byte-addressed bus.
// Operation
// [R1] On a downstream port the forwarding support bit is software writable, lockable, and resets to one.
// [R2] While the forwarding support bit is zero the companion forwarding enable bit reads zero and ignores writes.
// [R3] On an upstream port the forwarding support bit always reads zero and ignores writes.
// [R4] A software-written forwarding support value survives any change of the port operating mode.
// [R5] The relaxed posted passing bit reads one, and the ordering logic never lets a posted packet pass another on relaxed ordering.
// [R6] The completion timeout ranges field and the timeout disable support bit read zero.
// [R7] The atomic routing and all atomic and compare-and-swap completer bits read zero.
// [R8] The latency tolerance support bit reads zero.
// [R9] The processing hint completer support field reads zero.
// [R10] The extended format support bit reads zero.
// [R11] The end-to-end prefix support bit reads zero.
// [R12] Writes to read-only and reserved bits are ignored, and reserved bits read zero.
`default_nettype none
package dcap2_pkg;
   // ----------------------------------------
   // Addresses
   // ----------------------------------------
   localparam logic [11:0] DCAP2_CAP_OFFSET = 12'h064;
   localparam logic [11:0] DCAP2_CTL_OFFSET = 12'h068;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int DCAP2_FWD_SUPPORT_BIT = 5;
   localparam int DCAP2_NO_RELAX_BIT = 10;
   localparam int DCAP2_FWD_ENABLE_BIT = 5;
   localparam int DCAP2_LOCK_BIT = 0;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic DCAP2_FWD_SUPPORT_DS_RST = 1'h1;
   localparam logic DCAP2_FWD_SUPPORT_US_VAL = 1'h0;
   localparam logic DCAP2_FWD_ENABLE_RST = 1'h0;
   localparam logic DCAP2_NO_RELAX_VAL = 1'h1;
   localparam logic [31:0] DCAP2_ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== dcap2_cfg_if.sv
// Interface between the register bank and its field store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface dcap2_cfg_if;
   logic wr_cap;
   logic wr_ctl;
   logic wr_val;
   logic support;
   logic enable;
   modport bank (output wr_cap, output wr_ctl, output wr_val, input support, input enable);
   modport store (input wr_cap, input wr_ctl, input wr_val, output support, output enable);
endinterface
`default_nettype wire

// ===== dcap2_field_store.sv
// Holds the writable forwarding support and enable bits.
// Assumes writes come already decoded from the bank.
`timescale 1ns/1ps
`default_nettype none
module dcap2_field_store (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Port role and lock
   input wire logic downstream_i,
   input wire logic lock_i,
   // Bank side
   dcap2_cfg_if.store cfg
);
   logic support_q;
   logic enable_q;
   // ----------------------------------------
   // Support bit
   // ----------------------------------------
   // The mode input only gates writes here, so the value is sticky across mode changes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         support_q <= dcap2_pkg::DCAP2_FWD_SUPPORT_DS_RST; // R1
      end else if (cfg.wr_cap && downstream_i && !lock_i) begin
         support_q <= cfg.wr_val; // R1 R4
      end
   end
   // Enable bit, forced low when unsupported
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q <= dcap2_pkg::DCAP2_FWD_ENABLE_RST;
      end else if (!cfg.support) begin
         enable_q <= 1'h0; // R2
      end else if (cfg.wr_ctl) begin
         enable_q <= cfg.wr_val;
      end
   end
   assign cfg.support = downstream_i ? support_q : dcap2_pkg::DCAP2_FWD_SUPPORT_US_VAL; // R3
   assign cfg.enable = enable_q & cfg.support; // R2
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Only a bank write may move the stored bit, whatever the port mode does
   property p_sticky;
      @(posedge clk_i) disable iff (rst_i) !$past(cfg.wr_cap) |-> $stable(support_q);
   endproperty
   a_sticky: assert property (p_sticky) else $error("support changed without a write"); // R4
endmodule // dcap2_field_store
`default_nettype wire

// ===== dcap2_regs.sv
// Wishbone slave for the device capabilities two register and companion enable bit.
// Assumes a classic Wishbone master on clk_i; downstream_i (port mode) and lock_i are levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dcap2_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Port role and lock
   input wire logic downstream_i,
   input wire logic lock_i,
   // Status to port logic
   output logic fwd_enable_o,
   output logic relaxed_pass_block_o
);
   dcap2_cfg_if cfg ();
   logic ack_q;
   logic [31:0] dat_q;
   logic req;
   logic hit_cap;
   logic hit_ctl;
   logic [31:0] cap_word;
   logic [31:0] ctl_word;
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Answer one cycle after the request; ack drops the next cycle
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign hit_cap = (wb_adr_i == dcap2_pkg::DCAP2_CAP_OFFSET);
   assign hit_ctl = (wb_adr_i == dcap2_pkg::DCAP2_CTL_OFFSET);
   assign cfg.wr_cap = req && wb_we_i && hit_cap && wb_sel_i[0];
   assign cfg.wr_ctl = req && wb_we_i && hit_ctl && wb_sel_i[0];
   assign cfg.wr_val = wb_dat_i[dcap2_pkg::DCAP2_FWD_SUPPORT_BIT];
   // Read words: constant zero fields, only two live bits
   always_comb begin
      cap_word = dcap2_pkg::DCAP2_ZERO_WORD; // R6 R7 R8 R9 R10 R11 R12
      cap_word[dcap2_pkg::DCAP2_FWD_SUPPORT_BIT] = cfg.support;
      cap_word[dcap2_pkg::DCAP2_NO_RELAX_BIT] = dcap2_pkg::DCAP2_NO_RELAX_VAL; // R5
      ctl_word = dcap2_pkg::DCAP2_ZERO_WORD; // R12
      ctl_word[dcap2_pkg::DCAP2_FWD_ENABLE_BIT] = cfg.enable; // R2
   end
   // ----------------------------------------
   // Bus response
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'h0;
      end else begin
         ack_q <= req;
      end
   end
   // Unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= dcap2_pkg::DCAP2_ZERO_WORD;
      end else if (req && !wb_we_i) begin
         dat_q <= hit_cap ? cap_word : (hit_ctl ? ctl_word : dcap2_pkg::DCAP2_ZERO_WORD);
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign fwd_enable_o = cfg.enable;
   assign relaxed_pass_block_o = dcap2_pkg::DCAP2_NO_RELAX_VAL; // R5
   dcap2_field_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .downstream_i(downstream_i),
      .lock_i(lock_i),
      .cfg(cfg)
   );
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_up_zero;
      @(posedge clk_i) disable iff (rst_i) !downstream_i |-> !cfg.support;
   endproperty
   a_up_zero: assert property (p_up_zero) else $error("upstream support not zero"); // R3
   property p_en_gated;
      @(posedge clk_i) disable iff (rst_i) (!cfg.support || !$past(cfg.support)) |-> !fwd_enable_o;
   endproperty
   a_en_gated: assert property (p_en_gated) else $error("enable set without support"); // R2
   property p_wr_take;
      @(posedge clk_i) disable iff (rst_i) (cfg.wr_cap && downstream_i && !lock_i) |=> (cfg.support == $past(cfg.wr_val));
   endproperty
   a_wr_take: assert property (p_wr_take) else $error("support write lost"); // R1
   property p_locked;
      @(posedge clk_i) disable iff (rst_i) (lock_i && $past(lock_i) && downstream_i && $past(downstream_i)) |-> $stable(cfg.support);
   endproperty
   a_locked: assert property (p_locked) else $error("locked bit changed"); // R1
   property p_rd_cap;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> wb_ack_o && (wb_dat_o[31:22] == 10'h000) && (wb_dat_o[20:11] == 10'h000) && wb_dat_o[10] && (wb_dat_o[9:6] == 4'h0) && (wb_dat_o[4:0] == 5'h00);
   endproperty
   a_rd_cap: assert property (p_rd_cap) else $error("constant fields wrong"); // R6
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held"); // R12
   property p_no_pass;
      @(posedge clk_i) disable iff (rst_i) relaxed_pass_block_o;
   endproperty
   a_no_pass: assert property (p_no_pass) else $error("relaxed passing allowed"); // R5
   property p_rd_ctl;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_ctl) |=> (wb_dat_o == {26'h0, $past(cfg.enable), 5'h00});
   endproperty
   a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong"); // R2
   // ----------------------------------------
   // Field by field checks on capability reads
   // ----------------------------------------
   // One property per rule, so a failure names the broken rule directly
   property p_rd_ranges;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> (wb_dat_o[4:0] == 5'h00);
   endproperty
   a_rd_ranges: assert property (p_rd_ranges) else $error("timeout fields not zero"); // R6
   property p_rd_atomic;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> (wb_dat_o[9:6] == 4'h0);
   endproperty
   a_rd_atomic: assert property (p_rd_atomic) else $error("atomic bits not zero"); // R7
   property p_rd_relax;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> wb_dat_o[10];
   endproperty
   a_rd_relax: assert property (p_rd_relax) else $error("relaxed passing bit not one"); // R5
   property p_rd_ltr;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> !wb_dat_o[11];
   endproperty
   a_rd_ltr: assert property (p_rd_ltr) else $error("latency tolerance bit set"); // R8
   property p_rd_hint;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> (wb_dat_o[13:12] == 2'h0);
   endproperty
   a_rd_hint: assert property (p_rd_hint) else $error("hint completer field set"); // R9
   property p_rd_fmt;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> !wb_dat_o[20];
   endproperty
   a_rd_fmt: assert property (p_rd_fmt) else $error("extended format bit set"); // R10
   property p_rd_prefix;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> !wb_dat_o[21];
   endproperty
   a_rd_prefix: assert property (p_rd_prefix) else $error("prefix support bit set"); // R11
   property p_rd_resv;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap) |=> (wb_dat_o[19:14] == 6'h00) && (wb_dat_o[31:22] == 10'h000);
   endproperty
   a_rd_resv: assert property (p_rd_resv) else $error("reserved bits not zero"); // R12
   property p_rd_up;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_cap && !downstream_i) |=> !wb_dat_o[5];
   endproperty
   a_rd_up: assert property (p_rd_up) else $error("upstream read shows support"); // R3
   // ----------------------------------------
   // Control, unmapped and reset checks
   // ----------------------------------------
   property p_up_ctl;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && hit_ctl && !cfg.support) |=> (wb_dat_o == dcap2_pkg::DCAP2_ZERO_WORD);
   endproperty
   a_up_ctl: assert property (p_up_ctl) else $error("enable readable without support"); // R2
   property p_ctl_take;
      @(posedge clk_i) disable iff (rst_i) (cfg.wr_ctl && cfg.support) |=> (fwd_enable_o == $past(cfg.wr_val));
   endproperty
   a_ctl_take: assert property (p_ctl_take) else $error("enable write lost"); // R2
   property p_rd_unmapped;
      @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && !hit_cap && !hit_ctl) |=> (wb_dat_o == dcap2_pkg::DCAP2_ZERO_WORD);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // R12
   // Reset checks run without a disable so they see the reset itself
   property p_rst_support;
      @(posedge clk_i) (rst_i && downstream_i) |=> cfg.support;
   endproperty
   a_rst_support: assert property (p_rst_support) else $error("support default not one"); // R1
   property p_rst_quiet;
      @(posedge clk_i) rst_i |=> !wb_ack_o && (wb_dat_o == dcap2_pkg::DCAP2_ZERO_WORD) && !fwd_enable_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset"); // R2
   // ----------------------------------------
   // Bus handshake checks
   // ----------------------------------------
   // Ignored accesses must still complete, or the master would hang
   property p_ack_answer;
      @(posedge clk_i) disable iff (rst_i) req |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered"); // R12
   property p_ack_cause;
      @(posedge clk_i) disable iff (rst_i) wb_ack_o |-> $past(req);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request"); // R12
   property p_dat_hold;
      @(posedge clk_i) disable iff (rst_i) !$past(req && !wb_we_i) |-> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved without a read"); // R12
   c_wr_sup: cover property (@(posedge clk_i) cfg.wr_cap && downstream_i && !lock_i);
   c_en_on: cover property (@(posedge clk_i) fwd_enable_o);
   c_clear_drop: cover property (@(posedge clk_i) fwd_enable_o ##1 !cfg.support);
   c_up_read: cover property (@(posedge clk_i) req && !wb_we_i && hit_cap && !downstream_i);
   c_lock_hold: cover property (@(posedge clk_i) cfg.wr_cap && downstream_i && lock_i);
endmodule // dcap2_regs
`default_nettype wire

// ===== dcap2_tb_top.sv
// Self-checking bench for the device capabilities two register bank.
// Assumes dcap2_regs answers each Wishbone request with a one-cycle registered ack.
`timescale 1ns/1ps
`default_nettype none
module dcap2_tb_top;
   // ----------------------------------------
   // Signals and expected words
   // ----------------------------------------
   localparam logic [31:0] SUP = 32'h0000_0001 << dcap2_pkg::DCAP2_FWD_SUPPORT_BIT;
   localparam logic [31:0] NRX = 32'h0000_0001 << dcap2_pkg::DCAP2_NO_RELAX_BIT;
   localparam logic [31:0] ENA = 32'h0000_0001 << dcap2_pkg::DCAP2_FWD_ENABLE_BIT;
   localparam logic [11:0] CAP = dcap2_pkg::DCAP2_CAP_OFFSET;
   localparam logic [11:0] CTL = dcap2_pkg::DCAP2_CTL_OFFSET;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ds = 1'b1, lock = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [3:0] bsel = 4'hF;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, q;
   logic ack, fwd, relax;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   dcap2_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .downstream_i(ds), .lock_i(lock), .fwd_enable_o(fwd), .relaxed_pass_block_o(relax));
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Verdict and end of run, also reached on a hang
   task complete_run;
      $display("Counts: %0d checked, %0d failures", checked, failures);
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog, far above the roughly 120 cycles the tests need
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         $display("unexpected at %0t: timeout", $time);
         complete_run();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= bsel;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   // Reset into a given port role; mode changes without reset are tested separately
   task do_reset(input logic role);
      @(posedge clk_i);
      rst_i <= 1'b1;
      ds <= role;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      do_reset(1'b1);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, SUP | NRX, "cap reset");
      chk({31'h0, relax}, 32'h1, "relax block");
      wr(CAP, 32'hFFFF_FFFF);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, SUP | NRX, "cap ro");
      // Byte lane 0 off: the live bit must not move
      bsel = 4'hE;
      wr(CAP, 32'h0);
      bsel = 4'hF;
      wb(1'b0, CAP, 32'h0, q);
      chk(q, SUP | NRX, "lane off");
      wr(CTL, 32'hFFFF_FFFF);
      wb(1'b0, CTL, 32'h0, q);
      chk(q, ENA, "ctl set");
      chk({31'h0, fwd}, 32'h1, "enable out");
      wr(CAP, 32'h0);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "support clear");
      wb(1'b0, CTL, 32'h0, q);
      chk(q, 32'h0, "enable forced");
      wr(CTL, ENA);
      wb(1'b0, CTL, 32'h0, q);
      chk(q, 32'h0, "enable blocked");
      chk({31'h0, fwd}, 32'h0, "enable out low");
      wr(CAP, SUP);
      @(posedge clk_i);
      lock <= 1'b1;
      wr(CAP, 32'h0);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, SUP | NRX, "locked");
      @(posedge clk_i);
      lock <= 1'b0;
      wr(CAP, 32'h0);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "written kept");
      wb(1'b0, 12'h100, 32'h0, q);
      chk(q, 32'h0, "unmapped");
      // Mode switch without reset: the written zero must return, not the default one
      @(posedge clk_i);
      ds <= 1'b0;
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "mode up");
      @(posedge clk_i);
      ds <= 1'b1;
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "mode back");
      $display("test downstream done");
      do_reset(1'b0);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "up reset");
      wr(CAP, 32'hFFFF_FFFF);
      wb(1'b0, CAP, 32'h0, q);
      chk(q, NRX, "up write");
      wr(CTL, 32'hFFFF_FFFF);
      wb(1'b0, CTL, 32'h0, q);
      chk(q, 32'h0, "up enable");
      chk({31'h0, fwd}, 32'h0, "up enable out");
      $display("test upstream done");
      complete_run();
   end
endmodule // dcap2_tb_top
`default_nettype wire
